/* File: src/dcsw_drive_control_status_word.sv */
`include "dcsw_params.svh"
module dcsw_drive_control_status_word
   import dcsw_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic [15:0] i_cmd_word,
   input wire logic i_cmd_strobe,
   input wire dcsw_rel_t i_speed_ref,
   input wire dcsw_rel_t i_freq_core,
   input wire dcsw_state_s i_state,
   input wire dcsw_cfg_s i_cfg,
   input wire logic i_link_fault,
   output logic [15:0] o_drive_command_word,
   output dcsw_cmd_s o_cmd,
   output dcsw_stop_e o_stop,
   output logic o_trip_reset,
   output dcsw_rel_t o_speed_ref,
   output dcsw_rel_t o_actual_output_freq_value,
   output logic [15:0] o_drive_state_word
);
   ////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rst_meta_r;
   logic rst_sync_r;

   // Asynchronous assert, synchronous release
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command word capture
   logic [15:0] cmd_r;
   logic [15:0] cmd_nxt;
   logic accept_w;
   logic rst_bit_prev_r;
   logic rst_bit_prev_nxt;

   assign accept_w = i_cmd_strobe & i_cmd_word[`DCSW_CMD_VALID];
   assign cmd_nxt = accept_w ? i_cmd_word : cmd_r;

   assign rst_bit_prev_nxt = cmd_r[`DCSW_CMD_RESET];

   always_ff @(posedge i_core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
      begin
         cmd_r <= `DCSW_CMD_RST;
         rst_bit_prev_r <= 1'b0;
      end
      else
      begin
         cmd_r <= cmd_nxt;
         rst_bit_prev_r <= rst_bit_prev_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   logic coast_w;
   logic brake_w;
   logic qstop_w;
   logic rstop_w;
   logic hold_w;
   logic rst_edge_w;
   dcsw_cmd_s cmd_dec_w;
   dcsw_stop_e stop_dec_w;

   assign coast_w = ~cmd_r[`DCSW_CMD_COAST_N];
   assign brake_w = ~cmd_r[`DCSW_CMD_DC_BRAKE_N];
   assign hold_w = ~cmd_r[`DCSW_CMD_HOLD_N];
   assign qstop_w = ~cmd_r[`DCSW_CMD_QSTOP_N] & ~hold_w;
   assign rstop_w = ~cmd_r[`DCSW_CMD_START] & ~hold_w;
   assign rst_edge_w = cmd_r[`DCSW_CMD_RESET] & ~rst_bit_prev_r;

   // Stop priority: coast wins, then brake, quick stop, ramp stop
   assign stop_dec_w = coast_w ? DCSW_COAST :
                       brake_w ? DCSW_DC_BRAKE :
                       qstop_w ? DCSW_QUICK_STOP :
                       rstop_w ? DCSW_RAMP_STOP : DCSW_RUN;

   assign cmd_dec_w.preset_sel = {cmd_r[`DCSW_CMD_PRESET_HI],
                                  cmd_r[`DCSW_CMD_PRESET_LO]};
   assign cmd_dec_w.setup_sel = i_cfg.multi_setup ?
      {cmd_r[`DCSW_CMD_SETUP_HI], cmd_r[`DCSW_CMD_SETUP_LO]} : 2'h0;
   assign cmd_dec_w.coast = coast_w;
   assign cmd_dec_w.dc_brake = brake_w;
   assign cmd_dec_w.quick_stop = qstop_w;
   assign cmd_dec_w.ramp_stop = rstop_w;
   assign cmd_dec_w.hold_freq = hold_w;
   assign cmd_dec_w.jog = cmd_r[`DCSW_CMD_JOG];
   assign cmd_dec_w.ramp2 = cmd_r[`DCSW_CMD_RAMP2];
   assign cmd_dec_w.relay1 = cmd_r[`DCSW_CMD_RELAY1]
      & i_cfg.relay1_follows_bus;
   assign cmd_dec_w.relay2 = cmd_r[`DCSW_CMD_RELAY2]
      & i_cfg.relay2_follows_bus;
   assign cmd_dec_w.reverse = cmd_r[`DCSW_CMD_REVERSE]
      & i_cfg.reverse_from_bus;
   assign cmd_dec_w.start_ok = cmd_r[`DCSW_CMD_START] & ~coast_w
      & ~brake_w & ~qstop_w & ~hold_w;

   ////////////////////////////////////////////////////////////////////////
   // Output registers
   dcsw_cmd_s cmd_out_r;
   dcsw_stop_e stop_r;
   logic trip_reset_r;
   dcsw_rel_t ref_r;
   dcsw_rel_t freq_r;

   // Outputs from flops so the core sees clean levels
   always_ff @(posedge i_core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
      begin
         cmd_out_r <= '0;
         stop_r <= DCSW_RUN;
         trip_reset_r <= 1'b0;
         ref_r <= 16'sh0000;
         freq_r <= 16'sh0000;
      end
      else
      begin
         cmd_out_r <= cmd_dec_w;
         stop_r <= stop_dec_w;
         trip_reset_r <= rst_edge_w;
         ref_r <= i_speed_ref;
         freq_r <= i_freq_core;
      end
   end

   assign o_drive_command_word = cmd_r;
   assign o_cmd = cmd_out_r;
   assign o_stop = stop_r;
   assign o_trip_reset = trip_reset_r;
   assign o_speed_ref = ref_r;
   assign o_actual_output_freq_value = freq_r;

   ////////////////////////////////////////////////////////////////////////
   // Status word
   dcsw_status_word u_status
   (
      .i_core_clk(i_core_clk),
      .i_rst_sync_b(rst_sync_r),
      .i_state(i_state),
      .i_link_fault(i_link_fault),
      .o_word(o_drive_state_word)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_rst_rise;
      !cmd_r[`DCSW_CMD_RESET] ##1 cmd_r[`DCSW_CMD_RESET];
   endsequence

   property p_ignore_invalid;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      (i_cmd_strobe && !i_cmd_word[`DCSW_CMD_VALID]) |=> $stable(cmd_r);
   endproperty
   a_ignore_invalid: assert property (p_ignore_invalid)
      else $error("invalid command word was taken");

   property p_rst_pulse;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      s_rst_rise |=> o_trip_reset ##1 !o_trip_reset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse)
      else $error("trip reset not one pulse on rising edge");

   property p_rst_steady;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      cmd_r[`DCSW_CMD_RESET] [*2] |=> !o_trip_reset;
   endproperty
   a_rst_steady: assert property (p_rst_steady)
      else $error("trip reset on steady bit");

   property p_coast;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      !cmd_r[`DCSW_CMD_COAST_N] |=> o_stop == DCSW_COAST;
   endproperty
   a_coast: assert property (p_coast)
      else $error("coast not commanded");

   property p_hold_blocks;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      (!cmd_r[`DCSW_CMD_HOLD_N] && cmd_r[`DCSW_CMD_COAST_N]
       && cmd_r[`DCSW_CMD_DC_BRAKE_N]) |=> o_stop == DCSW_RUN;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks)
      else $error("bus ramp stop accepted while held");

   property p_relay1;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      !i_cfg.relay1_follows_bus |=> !o_cmd.relay1;
   endproperty
   a_relay1: assert property (p_relay1)
      else $error("relay 1 driven without configuration");

   property p_setup;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      i_cfg.multi_setup |=> o_cmd.setup_sel ==
         $past({cmd_r[`DCSW_CMD_SETUP_HI], cmd_r[`DCSW_CMD_SETUP_LO]});
   endproperty
   a_setup: assert property (p_setup)
      else $error("set-up select mismatch");

   property p_reverse;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      !i_cfg.reverse_from_bus |=> !o_cmd.reverse;
   endproperty
   a_reverse: assert property (p_reverse)
      else $error("reverse without bus source");

   // A word that carries the valid bit lands on the next edge
   property p_valid_take;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      (i_cmd_strobe && i_cmd_word[`DCSW_CMD_VALID])
         |=> o_drive_command_word == $past(i_cmd_word);
   endproperty
   a_valid_take: assert property (p_valid_take)
      else $error("valid command word not taken");

   property p_trip_edge;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      o_trip_reset |-> $past(cmd_r[`DCSW_CMD_RESET])
         && !$past(cmd_r[`DCSW_CMD_RESET], 2);
   endproperty
   a_trip_edge: assert property (p_trip_edge)
      else $error("trip reset without a rising reset bit");

   property p_brake;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      (cmd_r[`DCSW_CMD_COAST_N] && !cmd_r[`DCSW_CMD_DC_BRAKE_N])
         |=> o_stop == DCSW_DC_BRAKE;
   endproperty
   a_brake: assert property (p_brake)
      else $error("DC brake not commanded");

   // Quick stop only counts while the frequency is not held
   property p_qstop;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      (!cmd_r[`DCSW_CMD_QSTOP_N] && cmd_r[`DCSW_CMD_HOLD_N]
       && cmd_r[`DCSW_CMD_COAST_N] && cmd_r[`DCSW_CMD_DC_BRAKE_N])
         |=> o_stop == DCSW_QUICK_STOP;
   endproperty
   a_qstop: assert property (p_qstop)
      else $error("quick stop not commanded");

   property p_ramp_stop;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      (!cmd_r[`DCSW_CMD_START] && cmd_r[`DCSW_CMD_HOLD_N]
       && cmd_r[`DCSW_CMD_QSTOP_N] && cmd_r[`DCSW_CMD_COAST_N]
       && cmd_r[`DCSW_CMD_DC_BRAKE_N]) |=> o_stop == DCSW_RAMP_STOP;
   endproperty
   a_ramp_stop: assert property (p_ramp_stop)
      else $error("ramp stop not commanded");

   property p_ramp_set;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      o_cmd.ramp2 == $past(cmd_r[`DCSW_CMD_RAMP2]);
   endproperty
   a_ramp_set: assert property (p_ramp_set)
      else $error("ramp set choice mismatch");

   property p_relay2;
      @(posedge i_core_clk) disable iff (!rst_sync_r)
      !i_cfg.relay2_follows_bus |=> !o_cmd.relay2;
   endproperty
   a_relay2: assert property (p_relay2)
      else $error("relay 2 driven without configuration");
endmodule

/* File: src/dcsw_params.svh */
`ifndef DCSW_PARAMS_SVH
`define DCSW_PARAMS_SVH
// Command word bit positions
`define DCSW_CMD_PRESET_LO 0
`define DCSW_CMD_PRESET_HI 1
`define DCSW_CMD_DC_BRAKE_N 2
`define DCSW_CMD_COAST_N 3
`define DCSW_CMD_QSTOP_N 4
`define DCSW_CMD_HOLD_N 5
`define DCSW_CMD_START 6
`define DCSW_CMD_RESET 7
`define DCSW_CMD_JOG 8
`define DCSW_CMD_RAMP2 9
`define DCSW_CMD_VALID 10
`define DCSW_CMD_RELAY1 11
`define DCSW_CMD_RELAY2 12
`define DCSW_CMD_SETUP_LO 13
`define DCSW_CMD_SETUP_HI 14
`define DCSW_CMD_REVERSE 15
// State word bit positions
`define DCSW_ST_CTRL_READY 0
`define DCSW_ST_DRIVE_READY 1
`define DCSW_ST_ENABLE 2
`define DCSW_ST_TRIP 3
`define DCSW_ST_ERROR 4
`define DCSW_ST_RSVD 5
`define DCSW_ST_TRIPLOCK 6
`define DCSW_ST_WARNING 7
`define DCSW_ST_AT_REF 8
`define DCSW_ST_BUS_CTRL 9
`define DCSW_ST_FREQ_OK 10
`define DCSW_ST_RUNNING 11
`define DCSW_ST_AUTO_STOP 12
`define DCSW_ST_VOLT 13
`define DCSW_ST_TORQUE 14
`define DCSW_ST_TIMER 15
// Reset values and scaling
`define DCSW_CMD_RST 16'h0000
`define DCSW_ST_RST 16'h0000
`define DCSW_RSVD_VAL 1'b0
`define DCSW_REL_100PCT 16'h4000
`endif

/* File: src/dcsw_pkg.sv */
package dcsw_pkg;
   // Stop action decoded from the command word
   typedef enum logic [2:0] {
      DCSW_RUN,
      DCSW_COAST,
      DCSW_DC_BRAKE,
      DCSW_QUICK_STOP,
      DCSW_RAMP_STOP
   } dcsw_stop_e;
   // Drive commands towards the motor-control core
   typedef struct packed {
      logic [1:0] preset_sel;
      logic [1:0] setup_sel;
      logic coast;
      logic dc_brake;
      logic quick_stop;
      logic ramp_stop;
      logic hold_freq;
      logic jog;
      logic ramp2;
      logic relay1;
      logic relay2;
      logic reverse;
      logic start_ok;
   } dcsw_cmd_s;
   // Drive state flags from the motor-control core
   typedef struct packed {
      logic ctrl_ready;
      logic drive_ready;
      logic enabled;
      logic tripped;
      logic error;
      logic trip_locked;
      logic warning;
      logic at_reference;
      logic local_stop;
      logic ref_site_local;
      logic at_low_limit;
      logic at_high_limit;
      logic start_present;
      logic freq_nonzero;
      logic auto_stop_temp;
      logic dc_volt_bad;
      logic current_over;
      logic thermal_over;
   } dcsw_state_s;
   // Configuration settings that gate bus commands
   typedef struct packed {
      logic relay1_follows_bus;
      logic relay2_follows_bus;
      logic multi_setup;
      logic reverse_from_bus;
   } dcsw_cfg_s;
   typedef logic signed [15:0] dcsw_rel_t;
endpackage

/* File: src/dcsw_status_word.sv */
`include "dcsw_params.svh"
module dcsw_status_word
   import dcsw_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_sync_b,
   input wire dcsw_state_s i_state,
   input wire logic i_link_fault,
   output logic [15:0] o_word
);
   logic [15:0] word_nxt;
   logic [15:0] word_r;

   // Status assembly from the current state flags
   always_comb
   begin
      word_nxt = `DCSW_ST_RST;
      word_nxt[`DCSW_ST_CTRL_READY] = i_state.ctrl_ready & ~i_state.tripped;
      word_nxt[`DCSW_ST_DRIVE_READY] = i_state.drive_ready;
      word_nxt[`DCSW_ST_ENABLE] = i_state.enabled;
      word_nxt[`DCSW_ST_TRIP] = i_state.tripped;
      word_nxt[`DCSW_ST_ERROR] = i_state.error;
      word_nxt[`DCSW_ST_TRIPLOCK] = i_state.trip_locked;
      word_nxt[`DCSW_ST_WARNING] = i_state.warning;
      word_nxt[`DCSW_ST_RSVD] = `DCSW_RSVD_VAL;
      word_nxt[`DCSW_ST_AT_REF] = i_state.at_reference;
      word_nxt[`DCSW_ST_BUS_CTRL] = ~i_state.local_stop
         & ~i_state.ref_site_local;
      word_nxt[`DCSW_ST_FREQ_OK] = ~i_state.at_low_limit
         & ~i_state.at_high_limit;
      word_nxt[`DCSW_ST_RUNNING] = i_state.start_present
         | i_state.freq_nonzero;
      word_nxt[`DCSW_ST_AUTO_STOP] = i_state.auto_stop_temp;
      word_nxt[`DCSW_ST_VOLT] = i_state.dc_volt_bad;
      word_nxt[`DCSW_ST_TORQUE] = i_state.current_over;
      word_nxt[`DCSW_ST_TIMER] = i_state.thermal_over;
      if (i_link_fault)
      begin
         word_nxt = 16'h0000;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_sync_b)
   begin
      if (!i_rst_sync_b)
         word_r <= `DCSW_ST_RST;
      else
         word_r <= word_nxt;
   end

   assign o_word = word_r;

   property p_link_clear;
      @(posedge i_core_clk) disable iff (!i_rst_sync_b)
      i_link_fault |=> (word_r == 16'h0000);
   endproperty
   a_link_clear: assert property (p_link_clear)
      else $error("status word not cleared on link fault");

   property p_reserved;
      @(posedge i_core_clk) disable iff (!i_rst_sync_b)
      word_r[`DCSW_ST_RSVD] == `DCSW_RSVD_VAL;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved status bit not constant");

   property p_trip_ready;
      @(posedge i_core_clk) disable iff (!i_rst_sync_b)
      i_state.tripped |=> !word_r[`DCSW_ST_CTRL_READY];
   endproperty
   a_trip_ready: assert property (p_trip_ready)
      else $error("control ready shown while tripped");

   property p_trip_bit;
      @(posedge i_core_clk) disable iff (!i_rst_sync_b)
      !i_link_fault |=> word_r[`DCSW_ST_TRIP] == $past(i_state.tripped);
   endproperty
   a_trip_bit: assert property (p_trip_bit)
      else $error("trip status bit wrong");

   property p_running;
      @(posedge i_core_clk) disable iff (!i_rst_sync_b)
      (!i_link_fault && i_state.freq_nonzero)
         |=> word_r[`DCSW_ST_RUNNING];
   endproperty
   a_running: assert property (p_running)
      else $error("in operation bit missing");

   property p_freq_lim;
      @(posedge i_core_clk) disable iff (!i_rst_sync_b)
      (i_state.at_low_limit || i_state.at_high_limit)
         |=> !word_r[`DCSW_ST_FREQ_OK];
   endproperty
   a_freq_lim: assert property (p_freq_lim)
      else $error("frequency limit bit wrong");

   property p_bus_ctrl;
      @(posedge i_core_clk) disable iff (!i_rst_sync_b)
      (i_state.local_stop || i_state.ref_site_local)
         |=> !word_r[`DCSW_ST_BUS_CTRL];
   endproperty
   a_bus_ctrl: assert property (p_bus_ctrl)
      else $error("bus control bit set while local");
endmodule

/* File: tb/dcsw_bus_master_model.sv */
module dcsw_bus_master_model
   import dcsw_pkg::*;
(
   input wire logic i_core_clk,
   output logic [15:0] o_cmd_word,
   output logic o_cmd_strobe,
   output dcsw_rel_t o_speed_ref
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero, no word offered
   initial
   begin
      o_cmd_word = 16'hFFFF;
      o_cmd_strobe = 1'b0;
      o_speed_ref = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // one word per strobe
   task automatic send(input logic [15:0] w);
      @(posedge i_core_clk);
      o_cmd_strobe <= 1'b1;
      o_cmd_word <= w;
      @(posedge i_core_clk);
      o_cmd_strobe <= 1'b0;
      // Released word shows the inverse so a stale copy cannot pass
      o_cmd_word <= ~w;
   endtask

   task automatic set_ref(input dcsw_rel_t r);
      @(posedge i_core_clk);
      o_speed_ref <= r;
   endtask
endmodule

/* File: tb/tb_top.sv */
module tb_top
   import dcsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [15:0] cmd_word;
   logic cmd_strobe;
   dcsw_rel_t speed_ref;
   dcsw_rel_t i_freq_core = 16'h0000;
   dcsw_state_s i_state = '0;
   dcsw_cfg_s i_cfg = '0;
   logic i_link_fault = 1'b0;
   logic [15:0] o_drive_command_word;
   dcsw_cmd_s o_cmd;
   dcsw_stop_e o_stop;
   logic o_trip_reset;
   dcsw_rel_t o_speed_ref;
   dcsw_rel_t o_actual_output_freq_value;
   logic [15:0] o_drive_state_word;
   int mismatches = 0;
   int n_checks = 0;
   int pulses = 0;

   initial
   begin
      forever #4 i_core_clk = ~i_core_clk;
   end

   dcsw_bus_master_model dcsw_bus_master_model_inst (
      .i_core_clk(i_core_clk),
      .o_cmd_word(cmd_word),
      .o_cmd_strobe(cmd_strobe),
      .o_speed_ref(speed_ref)
   );

   dcsw_drive_control_status_word dcsw_drive_control_status_word_inst (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_cmd_word(cmd_word),
      .i_cmd_strobe(cmd_strobe),
      .i_speed_ref(speed_ref),
      .i_freq_core(i_freq_core),
      .i_state(i_state),
      .i_cfg(i_cfg),
      .i_link_fault(i_link_fault),
      .o_drive_command_word(o_drive_command_word),
      .o_cmd(o_cmd),
      .o_stop(o_stop),
      .o_trip_reset(o_trip_reset),
      .o_speed_ref(o_speed_ref),
      .o_actual_output_freq_value(o_actual_output_freq_value),
      .o_drive_state_word(o_drive_state_word)
   );

   // Count cycles with the reset pulse high; a long pulse counts once per cycle
   always @(posedge i_core_clk)
   begin
      if (o_trip_reset === 1'b1)
         pulses++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [17:0] got, input logic [17:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Decode latency is two edges; three leaves margin
   task automatic settle();
      repeat (3) @(posedge i_core_clk);
      #1;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   function automatic logic [15:0] exp_sw(dcsw_state_s s);
      exp_sw = {s.thermal_over, s.current_over, s.dc_volt_bad,
                s.auto_stop_temp, s.start_present | s.freq_nonzero,
                ~(s.at_low_limit | s.at_high_limit),
                ~(s.local_stop | s.ref_site_local), s.at_reference,
                s.warning, s.trip_locked, 1'b0, s.error, s.tripped,
                s.enabled, s.drive_ready, s.ctrl_ready & ~s.tripped};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic t_valid();
      dcsw_bus_master_model_inst.send(16'h047C);
      settle();
      chk(18'(o_drive_command_word), 18'h047C, "cmd word");
      dcsw_bus_master_model_inst.send(16'h0B00);
      settle();
      chk(18'(o_drive_command_word), 18'h047C, "invalid taken");
      chk(18'(o_stop), 18'(DCSW_RUN), "invalid stop");
      chk(18'(o_cmd.start_ok), 18'h1, "start ok");
      $display("test valid done");
   endtask

   task automatic t_stops();
      logic [15:0] w [8] = '{16'h047C, 16'h0474, 16'h0478, 16'h046C,
                             16'h043C, 16'h044C, 16'h0454, 16'h0448};
      dcsw_stop_e e [8] = '{DCSW_RUN, DCSW_COAST, DCSW_DC_BRAKE,
                            DCSW_QUICK_STOP, DCSW_RAMP_STOP, DCSW_RUN,
                            DCSW_COAST, DCSW_DC_BRAKE};
      for (int i = 0; i < 8; i++)
      begin
         dcsw_bus_master_model_inst.send(w[i]);
         settle();
         chk(18'(o_stop), 18'(e[i]), "stop");
         chk(18'(o_cmd.hold_freq), 18'(!w[i][5]), "hold");
         chk(18'(o_cmd.start_ok), 18'(&w[i][6:2]), "start");
      end
      $display("test stops done");
   endtask

   task automatic t_reset();
      logic [15:0] w [6] = '{16'h0400, 16'h0480, 16'h0480, 16'h0000,
                             16'h0480, 16'h0400};
      logic [17:0] e [6] = '{18'h0, 18'h1, 18'h0, 18'h0, 18'h0, 18'h0};
      int p0;
      for (int i = 0; i < 6; i++)
      begin
         p0 = pulses;
         dcsw_bus_master_model_inst.send(w[i]);
         settle();
         chk(18'(pulses - p0), e[i], "trip reset");
      end
      p0 = pulses;
      dcsw_bus_master_model_inst.send(16'h0480);
      settle();
      chk(18'(pulses - p0), 18'h1, "second edge");
      $display("test reset done");
   endtask

   task automatic t_fields();
      dcsw_cmd_s e;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge i_core_clk);
         i_cfg <= (k == 1) ? 4'hF : 4'h0;
         dcsw_bus_master_model_inst.send(16'hDF7E);
         settle();
         e = '0;
         e.preset_sel = 2'b10;
         e.setup_sel = (k == 1) ? 2'b10 : 2'b00;
         e.jog = 1'b1;
         e.ramp2 = 1'b1;
         e.relay1 = k[0];
         e.relay2 = k[0];
         e.reverse = k[0];
         e.start_ok = 1'b1;
         chk(18'(o_cmd), 18'(e), "fields");
      end
      $display("test fields done");
   endtask

   task automatic t_status();
      dcsw_state_s s;
      for (int i = 0; i < 18; i++)
      begin
         s = 18'(1) << i;
         @(posedge i_core_clk);
         i_state <= s;
         settle();
         chk(18'(o_drive_state_word), 18'(exp_sw(s)), "status");
      end
      s = '1;
      @(posedge i_core_clk);
      i_state <= s;
      i_link_fault <= 1'b1;
      settle();
      chk(18'(o_drive_state_word), 18'h0, "link fault");
      @(posedge i_core_clk);
      i_link_fault <= 1'b0;
      settle();
      chk(18'(o_drive_state_word), 18'(exp_sw(s)), "restored");
      $display("test status done");
   endtask

   task automatic t_scale();
      dcsw_rel_t r [2] = '{16'h4000, 16'h7FFF};
      dcsw_rel_t f [2] = '{16'hC000, 16'h8000};
      for (int i = 0; i < 2; i++)
      begin
         dcsw_bus_master_model_inst.set_ref(r[i]);
         i_freq_core <= f[i];
         settle();
         chk(18'(o_speed_ref), 18'(r[i]), "speed ref");
         chk(18'(o_actual_output_freq_value), 18'(f[i]), "freq");
      end
      $display("test scale done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: a hang ends the run through the same report
   initial
   begin
      #200us;
      mismatches++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report();
   end

   initial
   begin
      repeat (12) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      t_valid();
      t_stops();
      t_reset();
      t_fields();
      t_status();
      t_scale();
      final_report();
   end
endmodule
